/* dv/sensor_core_model.sv */
// measurement source in front of the register bank: result buses and strobes
// assumes emit is called from one bench process only
`timescale 1ns/1ps
module sensor_core_model
(
	input  wire logic        clk,
	output logic             sample,
	output logic [23:0]      press_raw,
	output logic [23:0]      press_filt,
	output logic [23:0]      temp_raw,
	output logic [23:0]      temp_filt,
	output logic             press_new,
	output logic             temp_new
);
	// ------------------------------
	// idle levels
	// ------------------------------
	initial
	begin
		{sample, press_new, temp_new} = 3'h0;
		{press_raw, press_filt, temp_raw, temp_filt} = '0;
	end
	// ------------------------------
	// one strobe cycle, then inverted results
	// ------------------------------
	task automatic emit(input logic [23:0] pr, pf, tr, tf, input logic s, pn, tn);
		@(posedge clk);
		{press_raw, press_filt, temp_raw, temp_filt} <= {pr, pf, tr, tf};
		{sample, press_new, temp_new} <= {s, pn, tn};
		@(posedge clk);
		{sample, press_new, temp_new} <= 3'h0;
		{press_raw, press_filt, temp_raw, temp_filt} <= ~{pr, pf, tr, tf};
	endtask
endmodule

/* dv/sensor_status_fifo_regs_bench.sv */
// self-checking bench of the sensor register bank
// assumes design files and sensor_core_model are compiled first
`timescale 1ns/1ps
`include "sensor_regs_defs.svh"
module sensor_status_fifo_regs_bench;
	import sensor_regs_pkg::*;
	logic        SYS_CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic [7:0]  ADDR = 8'h00;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	byte_t       WDATA = 8'h00;
	logic        CMD_BUSY = 1'b0;
	logic        CMD_FAIL = 1'b0;
	logic        CONF_FAIL = 1'b0;
	logic        FATAL = 1'b0;
	logic        SOFT_RESET = 1'b0;
	logic        CLK_EN = 1'b1;
	logic [7:0]  RDATA;
	logic        IRQ_LEVEL;
	logic [1:0]  SOURCE_SEL;
	logic        SAMPLE, PRESS_NEW, TEMP_NEW;
	logic [23:0] PRESS_RAW, PRESS_FILT, TEMP_RAW, TEMP_FILT;
	logic        rd_taken = 1'b0;
	logic [15:0] notes[$];
	logic [15:0] note_q;
	int          miscompares = 0;
	int          compares = 0;
	int          k, c;
	integer      seed = 32'hCC563F2D;
	logic [23:0] base, tv, tt;
	logic [23:0] cyc = 24'h000000;
	byte_t       ra[23] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0A, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
		8'h19, 8'h1A};
	byte_t       re[23] = '{`IDENT_VALUE, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h80, 8'h00,
		8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00, 8'h02,
		8'h02, 8'h02, 8'h00};

	sensor_regs DUT
	(
		.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .ADDR(ADDR), .WR(WR), .RD(RD),
		.WDATA(WDATA), .RDATA(RDATA), .SAMPLE(SAMPLE), .PRESS_RAW(PRESS_RAW),
		.PRESS_FILT(PRESS_FILT), .TEMP_RAW(TEMP_RAW), .TEMP_FILT(TEMP_FILT),
		.PRESS_NEW(PRESS_NEW), .TEMP_NEW(TEMP_NEW), .CMD_BUSY(CMD_BUSY), .CMD_FAIL(CMD_FAIL),
		.CONF_FAIL(CONF_FAIL), .FATAL(FATAL), .SOFT_RESET(SOFT_RESET),
		.IRQ_LEVEL(IRQ_LEVEL), .SOURCE_SEL(SOURCE_SEL)
	);
	sensor_core_model core
	(
		.clk(SYS_CLK), .sample(SAMPLE), .press_raw(PRESS_RAW), .press_filt(PRESS_FILT),
		.temp_raw(TEMP_RAW), .temp_filt(TEMP_FILT), .press_new(PRESS_NEW),
		.temp_new(TEMP_NEW)
	);

	always #2 SYS_CLK = ~SYS_CLK;

	// ------------------------------
	// compares and verdict
	// ------------------------------
	task automatic conclude();
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] got, exp, m);
		compares++;
		if ((got & m) !== (exp & m))
		begin
			miscompares++;
			$display("MISMATCH %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_sig(input logic [1:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t output %b expected %b", $time, got, exp);
		end
	endtask
	// ------------------------------
	// register port driver
	// ------------------------------
	task automatic rd(input logic [7:0] a, e, m = 8'hFF);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		notes.push_back({m, e});
		@(posedge SYS_CLK);
		RD <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask
	task automatic frame(input byte_t h, input logic [23:0] t, p);
		rd(8'h14, h);
		for (int i = 0; i < 3; i++)
			if (h[1])
				rd(8'h14, t[8*i +: 8]);
		for (int i = 0; i < 3; i++)
			if (h[0])
				rd(8'h14, p[8*i +: 8]);
	endtask
	task automatic wait_lvl(input logic v);
		int n;
		#1;
		for (n = 0; n < 8 && IRQ_LEVEL !== v; n++)
		begin
			@(posedge SYS_CLK);
			#1;
		end
		if (n == 8)
		begin
			miscompares++;
			$display("MISMATCH %0t interrupt level stuck", $time);
			conclude();
		end
		else
			check_sig({1'b0, IRQ_LEVEL}, {1'b0, v});
	endtask
	task automatic sense(input logic [23:0] p);
		core.emit(p, ~p, tv, ~tv, 1'b1, 1'b0, 1'b0);
		// let the whole frame stream into the queue
		repeat (7) @(posedge SYS_CLK);
	endtask

	// ------------------------------
	// read data monitor
	// ------------------------------
	always @(posedge SYS_CLK)
		rd_taken <= RD;
	// expected sensor time: enabled edges since reset release
	always @(posedge SYS_CLK)
		if (RESETN && CLK_EN)
			cyc <= cyc + 24'h000001;
	always @(negedge SYS_CLK)
		if (rd_taken === 1'b1)
		begin
			if (notes.size() == 0)
			begin
				miscompares++;
				$display("MISMATCH %0t unexpected read data", $time);
			end
			else
			begin
				note_q = notes.pop_front();
				check_byte(RDATA, note_q[7:0], note_q[15:8]);
			end
		end

	initial
	begin
		#400000;
		miscompares++;
		conclude();
	end

	// ------------------------------
	// scenarios
	// ------------------------------
	initial
	begin
		base = 24'($random(seed));
		tv = 24'($random(seed));
		repeat (2) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		for (k = 0; k < 23; k++)
			rd(ra[k], re[k]);
		rd(8'h10, 8'h00);
		@(posedge SYS_CLK);
		{CMD_FAIL, CONF_FAIL, FATAL} <= 3'h7;
		@(posedge SYS_CLK);
		{CMD_FAIL, CONF_FAIL} <= 2'h0;
		rd(8'h02, 8'h07);
		rd(8'h02, 8'h01);
		FATAL <= 1'b0;
		CMD_BUSY <= 1'b1;
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h00);
		CMD_BUSY <= 1'b0;
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h01);
		wr(8'h17, 8'hE0);
		rd(8'h17, 8'h00);
		wr(8'h18, 8'hE0);
		rd(8'h18, 8'h00);
		wr(8'h00, 8'h55);
		rd(8'h00, `IDENT_VALUE);
		wr(8'h19, 8'h40);
		core.emit(base, ~base, tv, ~tv, 1'b0, 1'b1, 1'b0);
		wait_lvl(1'b1);
		rd(8'h11, 8'h08);
		wait_lvl(1'b0);
		rd(8'h03, 8'h30);
		rd(8'h05, base[15:8]);
		rd(8'h03, 8'h10);
		rd(8'h04, base[7:0]);
		rd(8'h06, base[23:16]);
		wr(8'h19, 8'h00);
		core.emit(base, ~base, tv, ~tv, 1'b0, 1'b0, 1'b1);
		rd(8'h11, 8'h00);
		wait_lvl(1'b0);
		rd(8'h03, 8'h50);
		rd(8'h09, tv[23:16]);
		rd(8'h03, 8'h10);
		rd(8'h07, tv[7:0]);
		rd(8'h08, tv[15:8]);
		wr(8'h17, 8'h19);
		for (c = 0; c < 4; c++)
		begin
			wr(8'h18, 8'(c << 3));
			rd(8'h18, 8'(c << 3));
			#1;
			check_sig(SOURCE_SEL, (c == 1) ? 2'b01 : 2'b00);
			sense(base);
			rd(8'h12, 8'h07);
			frame(8'h87, (c == 1) ? ~tv : tv, (c == 1) ? ~base : base);
		end
		wr(8'h17, 8'h11);
		sense(base);
		frame(8'h86, tv, base);
		wr(8'h17, 8'h18);
		sense(base);
		rd(8'h12, 8'h00);
		wr(8'h17, 8'h19);
		wr(8'h18, 8'h02);
		repeat (8) sense(base);
		rd(8'h12, 8'h0E);
		repeat (2) frame(8'h87, tv, base);
		rd(8'h14, 8'h80);
		wr(8'h18, 8'h00);
		wr(8'h17, 8'h09);
		wr(8'h15, 8'hFF);
		wr(8'h16, 8'h01);
		rd(8'h15, 8'hFF);
		rd(8'h16, 8'h01);
		wr(8'h19, 8'h18);
		for (k = 0; k < 129; k++)
			sense(base + 24'(k));
		rd(8'h12, 8'hFF);
		rd(8'h13, 8'h01);
		wait_lvl(1'b1);
		rd(8'h11, 8'h03);
		for (k = 1; k < 129; k++)
			frame(8'h85, tv, base + 24'(k));
		rd(8'h14, 8'h80);
		wr(8'h17, 8'h0B);
		for (k = 0; k < 129; k++)
			sense(base + 24'(k));
		rd(8'h13, 8'h01);
		for (k = 0; k < 128; k++)
			frame(8'h85, tv, base + 24'(k));
		wr(8'h17, 8'h0F);
		rd(8'h14, 8'hA0);
		@(posedge SYS_CLK);
		SOFT_RESET <= 1'b1;
		@(posedge SYS_CLK);
		SOFT_RESET <= 1'b0;
		rd(8'h10, 8'h01);
		rd(8'h10, 8'h00);
		// frozen edges must not advance the sensor time
		CLK_EN <= 1'b0;
		repeat (5) @(posedge SYS_CLK);
		CLK_EN <= 1'b1;
		#1;
		tt = cyc + 24'h000001;
		rd(8'h0C, tt[7:0]);
		rd(8'h0D, tt[15:8]);
		rd(8'h0E, tt[23:16]);
		repeat (4) @(posedge SYS_CLK);
		conclude();
	end
endmodule

/* hw/byte_queue.sv */
// 512-entry byte queue in flip-flops; overwrites oldest when pushed full
// assumes owner never pops when empty
`timescale 1ns/1ps
`include "sensor_regs_defs.svh"
module byte_queue
(
	input  wire logic SYS_CLK,
	input  wire logic RESETN,
	input  wire logic CLK_EN,
	queue_if.store    q
);
	import sensor_regs_pkg::*;
	byte_t       mem [`Q_DEPTH];
	logic  [8:0] wr_q;
	logic  [8:0] rd_q;
	logic  [9:0] cnt_q;
	wire         do_pop  = q.pop && (cnt_q != 10'h000);
	wire         is_full = (cnt_q == 10'h200);
	wire         drop    = q.push && is_full && !do_pop;
	assign q.head  = mem[rd_q];
	assign q.fill  = is_full ? 9'h1FF : cnt_q[8:0];
	assign q.full  = is_full;
	assign q.empty = (cnt_q == 10'h000);
	always_ff @(posedge SYS_CLK or negedge RESETN)
	if (!RESETN)
	begin
		wr_q  <= 9'h000;
		rd_q  <= 9'h000;
		cnt_q <= 10'h000;
	end
	else if (CLK_EN)
	begin
		if (q.flush)
		begin
			wr_q  <= 9'h000;
			rd_q  <= 9'h000;
			cnt_q <= 10'h000;
		end
		else
		begin
			if (q.push)
				wr_q <= wr_q + 9'h001;
			if (do_pop || drop)
				rd_q <= rd_q + 9'h001;
			if (q.push && !do_pop && !is_full)
				cnt_q <= cnt_q + 10'h001;
			else if (do_pop && !q.push)
				cnt_q <= cnt_q - 10'h001;
		end
	end
	always_ff @(posedge SYS_CLK)
	if (CLK_EN && q.push && !q.flush)
		mem[wr_q] <= q.push_data;
endmodule

/* hw/queue_if.sv */
// carrier between the register bank and its byte queue
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface queue_if;
	import sensor_regs_pkg::*;
	logic  push;
	byte_t push_data;
	logic  pop;
	logic  flush;
	byte_t head;
	fill_t fill;
	logic  full;
	logic  empty;
	modport owner (output push, push_data, pop, flush, input head, fill, full, empty);
	modport store (input push, push_data, pop, flush, output head, fill, full, empty);
endinterface

/* hw/sensor_regs.sv */
// register bank of a barometric sensor: flags, results, time, queue, queue setup
// assumes a byte register port with one-cycle read and write strobes
// Notes on behaviour
// - command failure bit 1, clears on read
// - configuration error bit 2, clears on read
// - status bit 4 high when commands accepted
// - pressure ready bit 5, clears on read
// - temperature ready bit 6, clears on read
// - pressure result little-endian at 0x04..0x06
// - temperature result little-endian at 0x07..0x09
// - sensor time little-endian at 0x0C..0x0E
// - power-up event bit set, clears on read
// - irq flags watermark, full, ready; read clears
// - nine-bit queue fill split over two
// - queue data port pops one byte
// - host writes nine-bit watermark, stored
// - queue runs only when mode bit set
// - stop-on-full blocks writes into full queue
// - time frame after last data frame
// - pressure stored only when enabled
// - temperature stored only when enabled
// - subsample queue writes by 2^field
// - source select; reserved codes act unfiltered
// - identification register returns fixed code
// - irq flags gated by their enables
`timescale 1ns/1ps
`include "sensor_regs_defs.svh"
module sensor_regs
(
	input  wire logic                  SYS_CLK,
	input  wire logic                  RESETN,
	input  wire logic                  CLK_EN,
	input  wire logic [7:0]            ADDR,
	input  wire logic                  WR,
	input  wire logic                  RD,
	input  wire sensor_regs_pkg::byte_t WDATA,
	output logic      [7:0]            RDATA,
	input  wire logic                  SAMPLE,
	input  wire logic [23:0]           PRESS_RAW,
	input  wire logic [23:0]           PRESS_FILT,
	input  wire logic [23:0]           TEMP_RAW,
	input  wire logic [23:0]           TEMP_FILT,
	input  wire logic                  PRESS_NEW,
	input  wire logic                  TEMP_NEW,
	input  wire logic                  CMD_BUSY,
	input  wire logic                  CMD_FAIL,
	input  wire logic                  CONF_FAIL,
	input  wire logic                  FATAL,
	input  wire logic                  SOFT_RESET,
	output logic                       IRQ_LEVEL,
	output logic      [1:0]            SOURCE_SEL
);
	import sensor_regs_pkg::*;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic  [23:0] press_q;
	logic  [23:0] temp_q;
	logic  [23:0] time_q;
	logic  [15:0] time_snap_q;
	logic         cmd_err_q;
	logic         conf_err_q;
	logic         fatal_q;
	logic         cmd_rdy_q;
	logic         drdy_p_q;
	logic         drdy_t_q;
	logic         por_q;
	logic         irq_wtm_q;
	logic         irq_full_q;
	logic         irq_drdy_q;
	fill_t        thr_q;
	logic  [4:0]  frame_cfg_q;
	logic  [4:0]  src_cfg_q;
	logic  [6:0]  irq_ctrl_q;
	logic  [6:0]  sub_cnt_q;
	logic  [1:0]  frame_idx_q;
	logic  [23:0] time_frame_q;
	logic         time_sent_q;

	queue_if qi ();
	byte_queue u_queue
	(
		.SYS_CLK (SYS_CLK),
		.RESETN  (RESETN),
		.CLK_EN  (CLK_EN),
		.q       (qi.store)
	);

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	wire rd_err    = RD && (ADDR == `OFS_ERROR);
	wire rd_press  = RD && (ADDR >= `OFS_PRESS_LO) && (ADDR <= `OFS_PRESS_HI);
	wire rd_temp   = RD && (ADDR >= `OFS_TEMP_LO) && (ADDR <= `OFS_TEMP_HI);
	wire rd_event  = RD && (ADDR == `OFS_EVENT);
	wire rd_irq    = RD && (ADDR == `OFS_IRQ);
	wire rd_qdata  = RD && (ADDR == `OFS_QDATA);
	wire rd_time0  = RD && (ADDR == `OFS_TIME_LO);
	wire wr_thr_lo = WR && (ADDR == `OFS_THR_LO);
	wire wr_thr_hi = WR && (ADDR == `OFS_THR_HI);
	wire wr_frame  = WR && (ADDR == `OFS_FRAME_CFG);
	wire wr_src    = WR && (ADDR == `OFS_SRC_CFG);
	wire wr_ictl   = WR && (ADDR == `OFS_IRQ_CTRL);
	wire q_on      = frame_cfg_q[`FC_MODE_BIT];
	wire stop_full = frame_cfg_q[`FC_STOP_BIT];
	wire time_en   = frame_cfg_q[`FC_TIME_BIT];
	wire p_en      = frame_cfg_q[`FC_PRESS_BIT];
	wire t_en      = frame_cfg_q[`FC_TEMP_BIT];

	// ------------------------------------------------------------
	// sample selection and subsampling
	// ------------------------------------------------------------
	wire        use_filt = (src_cfg_q[4:3] == SRC_FILT);
	wire [23:0] p_sel    = use_filt ? PRESS_FILT : PRESS_RAW;
	wire [23:0] t_sel    = use_filt ? TEMP_FILT : TEMP_RAW;
	wire [6:0]  sub_mask = 7'((8'h01 << src_cfg_q[2:0]) - 8'h01);
	wire        sub_hit  = ((sub_cnt_q & sub_mask) == 7'h00);
	wire        frame_go = SAMPLE && q_on && sub_hit && (p_en || t_en);

	// data frame header; independent of the time frame read index
	wire [7:0]  frame_byte = {6'b100001, t_en, p_en};

	// ------------------------------------------------------------
	// queue push: frame streamed as header + payload over cycles
	// ------------------------------------------------------------
	logic [55:0] fr_buf_q;
	logic [2:0]  fr_left_q;
	wire  [2:0]  fr_len   = 3'd1 + (t_en ? 3'd3 : 3'd0) + (p_en ? 3'd3 : 3'd0);
	wire  [55:0] fr_pack  = t_en && p_en ? {p_sel, t_sel, frame_byte}
	                      : t_en ? {24'h000000, t_sel, frame_byte}
	                      : {24'h000000, p_sel, frame_byte};
	wire         blocked  = stop_full && qi.full;
	assign qi.push      = (fr_left_q != 3'd0) && !blocked;
	assign qi.push_data = fr_buf_q[7:0];
	assign qi.flush     = !q_on;

	// ------------------------------------------------------------
	// queue read port with trailing time frame
	// ------------------------------------------------------------
	wire q_empty   = qi.empty && (fr_left_q == 3'd0);
	wire give_time = q_empty && time_en && !time_sent_q;
	assign qi.pop  = rd_qdata && !qi.empty;
	logic [7:0] q_byte;
	always_comb
	begin
		q_byte = 8'h00;
		if (!qi.empty)
			q_byte = qi.head;
		else if (give_time)
			case (frame_idx_q)
				2'd0:    q_byte = `TIME_FRAME_HDR;
				2'd1:    q_byte = time_frame_q[7:0];
				2'd2:    q_byte = time_frame_q[15:8];
				default: q_byte = time_frame_q[23:16];
			endcase
		else
			q_byte = `EMPTY_FRAME_HDR;
	end

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = 8'h00;
		case (ADDR)
			`OFS_IDENT:      rd_mux = `IDENT_VALUE;
			`OFS_ERROR:      rd_mux = {5'h00, conf_err_q, cmd_err_q, fatal_q};
			`OFS_STATUS:     rd_mux = {1'b0, drdy_t_q, drdy_p_q, cmd_rdy_q, 4'h0};
			`OFS_PRESS_LO:   rd_mux = press_q[7:0];
			`OFS_PRESS_MID:  rd_mux = press_q[15:8];
			`OFS_PRESS_HI:   rd_mux = press_q[23:16];
			`OFS_TEMP_LO:    rd_mux = temp_q[7:0];
			`OFS_TEMP_MID:   rd_mux = temp_q[15:8];
			`OFS_TEMP_HI:    rd_mux = temp_q[23:16];
			`OFS_TIME_LO:    rd_mux = time_q[7:0];
			`OFS_TIME_MID:   rd_mux = time_snap_q[7:0];
			`OFS_TIME_HI:    rd_mux = time_snap_q[15:8];
			`OFS_EVENT:      rd_mux = {7'h00, por_q};
			`OFS_IRQ:        rd_mux = {4'h0, irq_drdy_q, 1'b0, irq_full_q, irq_wtm_q};
			`OFS_FILL_LO:    rd_mux = qi.fill[7:0];
			`OFS_FILL_HI:    rd_mux = {7'h00, qi.fill[8]};
			`OFS_QDATA:      rd_mux = q_byte;
			`OFS_THR_LO:     rd_mux = thr_q[7:0];
			`OFS_THR_HI:     rd_mux = {7'h00, thr_q[8]};
			`OFS_FRAME_CFG:  rd_mux = {3'h0, frame_cfg_q};
			`OFS_SRC_CFG:    rd_mux = {3'h0, src_cfg_q};
			`OFS_IRQ_CTRL:   rd_mux = {1'b0, irq_ctrl_q};
			default:         rd_mux = 8'h00;
		endcase
	end
	wire wtm_hit  = q_on && (qi.fill >= thr_q) && (thr_q != 9'h000);
	wire wtm_ev   = wtm_hit && irq_ctrl_q[`IC_WTM_BIT];
	wire full_ev  = qi.full && irq_ctrl_q[`IC_FULL_BIT];
	wire drdy_ev  = (PRESS_NEW || TEMP_NEW) && irq_ctrl_q[`IC_DRDY_BIT];

	// ------------------------------------------------------------
	// flags: set wins over clear-on-read
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESETN)
	if (!RESETN)
	begin
		cmd_err_q  <= 1'b0;
		conf_err_q <= 1'b0;
		fatal_q    <= 1'b0;
		cmd_rdy_q  <= 1'b1;
		drdy_p_q   <= 1'b0;
		drdy_t_q   <= 1'b0;
		por_q      <= 1'b1;
		irq_wtm_q  <= 1'b0;
		irq_full_q <= 1'b0;
		irq_drdy_q <= 1'b0;
		IRQ_LEVEL  <= 1'b0;
	end
	else if (CLK_EN)
	begin
		cmd_err_q  <= CMD_FAIL || (cmd_err_q && !rd_err);
		conf_err_q <= CONF_FAIL || (conf_err_q && !rd_err);
		fatal_q    <= FATAL;
		cmd_rdy_q  <= !CMD_BUSY;
		drdy_p_q   <= PRESS_NEW || (drdy_p_q && !rd_press);
		drdy_t_q   <= TEMP_NEW || (drdy_t_q && !rd_temp);
		por_q      <= SOFT_RESET || (por_q && !rd_event);
		irq_wtm_q  <= wtm_ev || (irq_wtm_q && !rd_irq);
		irq_full_q <= full_ev || (irq_full_q && !rd_irq);
		irq_drdy_q <= drdy_ev || (irq_drdy_q && !rd_irq);
		IRQ_LEVEL  <= wtm_ev || full_ev || drdy_ev
		              || ((irq_wtm_q || irq_full_q || irq_drdy_q) && !rd_irq);
	end

	// ------------------------------------------------------------
	// results, time, configuration
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESETN)
	if (!RESETN)
	begin
		press_q     <= `RST_PRESS;
		temp_q      <= `RST_TEMP;
		time_q      <= 24'h000000;
		time_snap_q <= 16'h0000;
		thr_q       <= `RST_THR;
		frame_cfg_q <= `RST_FRAME_CFG;
		src_cfg_q   <= `RST_SRC_CFG;
		irq_ctrl_q  <= `RST_IRQ_CTRL;
		SOURCE_SEL  <= 2'b00;
		RDATA       <= 8'h00;
	end
	else if (CLK_EN)
	begin
		if (PRESS_NEW)
			press_q <= PRESS_RAW;
		if (TEMP_NEW)
			temp_q <= TEMP_RAW;
		time_q <= time_q + 24'h000001;
		if (rd_time0)
			time_snap_q <= time_q[23:8];
		if (wr_thr_lo)
			thr_q[7:0] <= WDATA;
		if (wr_thr_hi)
			thr_q[8] <= WDATA[0];
		if (wr_frame)
			frame_cfg_q <= WDATA[4:0];
		if (wr_src)
			src_cfg_q <= WDATA[4:0];
		if (wr_ictl)
			irq_ctrl_q <= {WDATA[6], 1'b0, WDATA[4:0]};
		SOURCE_SEL <= use_filt ? 2'b01 : 2'b00;
		if (RD)
			RDATA <= rd_mux;
	end

	// ------------------------------------------------------------
	// frame builder and time frame sequencing
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESETN)
	if (!RESETN)
	begin
		sub_cnt_q    <= 7'h00;
		fr_buf_q     <= 56'h0;
		fr_left_q    <= 3'd0;
		frame_idx_q  <= 2'd0;
		time_frame_q <= 24'h000000;
		time_sent_q  <= 1'b0;
	end
	else if (CLK_EN)
	begin
		if (!q_on)
			sub_cnt_q <= 7'h00;
		else if (SAMPLE)
			sub_cnt_q <= sub_cnt_q + 7'h01;
		if (frame_go && (fr_left_q == 3'd0) && !blocked)
		begin
			fr_buf_q  <= fr_pack;
			fr_left_q <= fr_len;
		end
		else if (qi.push)
		begin
			fr_buf_q  <= {8'h00, fr_buf_q[55:8]};
			fr_left_q <= fr_left_q - 3'd1;
		end
		if (!q_on || !qi.empty)
		begin
			time_sent_q <= 1'b0;
			frame_idx_q <= 2'd0;
		end
		else if (rd_qdata && give_time)
		begin
			if (frame_idx_q == 2'd0)
				time_frame_q <= time_q;
			frame_idx_q <= frame_idx_q + 2'd1;
			if (frame_idx_q == 2'd3)
				time_sent_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_cmd_err_clear;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && rd_err && !CMD_FAIL |=> !cmd_err_q;
	endproperty
	a_cmd_err_clear: assert property (p_cmd_err_clear) else $error("cmd error not cleared");
	property p_conf_err_set;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && CONF_FAIL |=> conf_err_q;
	endproperty
	a_conf_err_set: assert property (p_conf_err_set) else $error("conf error lost");
	property p_drdy_press;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && rd_press && !PRESS_NEW |=> !drdy_p_q;
	endproperty
	a_drdy_press: assert property (p_drdy_press) else $error("pressure ready stuck");
	property p_drdy_temp;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && TEMP_NEW |=> drdy_t_q && temp_q == $past(TEMP_RAW);
	endproperty
	a_drdy_temp: assert property (p_drdy_temp) else $error("temperature ready missing");
	property p_por_clear;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && rd_event && !SOFT_RESET |=> !por_q;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("event flag not cleared");
	property p_irq_gate;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && rd_irq && !wtm_ev && !full_ev && !drdy_ev |=> !IRQ_LEVEL;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not cleared");
	property p_ident;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && RD && ADDR == `OFS_IDENT |=> RDATA == `IDENT_VALUE;
	endproperty
	a_ident: assert property (p_ident) else $error("bad identification");
	property p_queue_off;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && !q_on |=> qi.fill == 9'h000;
	endproperty
	a_queue_off: assert property (p_queue_off) else $error("queue holds data while off");
	property p_stop_full;
		@(posedge SYS_CLK) disable iff (!RESETN)
		CLK_EN && q_on && stop_full && qi.full && !qi.pop |-> !qi.push ##1 $stable(qi.head);
	endproperty
	a_stop_full: assert property (p_stop_full) else $error("write into full queue");
endmodule

/* hw/sensor_regs_defs.svh */
// register offsets, field positions and reset values of the sensor register bank
// assumes byte-wide registers at 8-bit addresses
`ifndef SENSOR_REGS_DEFS_SVH
`define SENSOR_REGS_DEFS_SVH
`define OFS_IDENT        8'h00
`define OFS_ERROR        8'h02
`define OFS_STATUS       8'h03
`define OFS_PRESS_LO     8'h04
`define OFS_PRESS_MID    8'h05
`define OFS_PRESS_HI     8'h06
`define OFS_TEMP_LO      8'h07
`define OFS_TEMP_MID     8'h08
`define OFS_TEMP_HI      8'h09
`define OFS_TIME_LO      8'h0C
`define OFS_TIME_MID     8'h0D
`define OFS_TIME_HI      8'h0E
`define OFS_EVENT        8'h10
`define OFS_IRQ          8'h11
`define OFS_FILL_LO      8'h12
`define OFS_FILL_HI      8'h13
`define OFS_QDATA        8'h14
`define OFS_THR_LO       8'h15
`define OFS_THR_HI       8'h16
`define OFS_FRAME_CFG    8'h17
`define OFS_SRC_CFG      8'h18
`define OFS_IRQ_CTRL     8'h19
// identification value is arbitrary
`define IDENT_VALUE      8'hA7
`define RST_PRESS        24'h800000
`define RST_TEMP         24'h800000
`define RST_THR          9'h001
`define RST_FRAME_CFG    5'h02
`define RST_SRC_CFG      5'h02
`define RST_IRQ_CTRL     7'h02
`define ERR_FATAL_BIT    0
`define ERR_CMD_BIT      1
`define ERR_CONF_BIT     2
`define ST_CMDRDY_BIT    4
`define ST_DRDYP_BIT     5
`define ST_DRDYT_BIT     6
`define IRQ_WTM_BIT      0
`define IRQ_FULL_BIT     1
`define IRQ_DRDY_BIT     3
`define FC_MODE_BIT      0
`define FC_STOP_BIT      1
`define FC_TIME_BIT      2
`define FC_PRESS_BIT     3
`define FC_TEMP_BIT      4
`define IC_WTM_BIT       3
`define IC_FULL_BIT      4
`define IC_DRDY_BIT      6
`define Q_DEPTH          512
`define TIME_FRAME_HDR   8'hA0
`define EMPTY_FRAME_HDR  8'h80
`endif

/* hw/sensor_regs_pkg.sv */
// types shared by the sensor register bank
// assumes sensor_regs_defs.svh is on the include path
package sensor_regs_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [8:0] fill_t;
	typedef enum logic [1:0] {SRC_RAW, SRC_FILT, SRC_RSV2, SRC_RSV3} src_e;
endpackage
